// ===== shared/ndoc_regs.vh
// Register map, field positions, reset values and timing counts of the directional overcurrent element
`ifndef NDOC_REGS_VH
`define NDOC_REGS_VH

`define NDOC_OFF_CTRL 6'h00
`define NDOC_OFF_RESTRAINT 6'h01
`define NDOC_OFF_OFFSET 6'h02
`define NDOC_OFF_ANGLES 6'h03
`define NDOC_OFF_FWD_PICKUP 6'h04
`define NDOC_OFF_REV_PICKUP 6'h05
`define NDOC_OFF_CUTOFF 6'h06
`define NDOC_OFF_STATUS 6'h07
`define NDOC_OFF_EVENT 6'h08

`define NDOC_CTRL_EN 0
`define NDOC_CTRL_SRC_LO 1
`define NDOC_CTRL_POL_LO 3
`define NDOC_CTRL_PVSEL 5
`define NDOC_CTRL_OPSEL 6
`define NDOC_CTRL_EVEN 7
`define NDOC_ANG_ECA_LO 0
`define NDOC_ANG_FLIM_LO 8
`define NDOC_ANG_RLIM_LO 16

`define NDOC_SRC_LINE 2'h0
`define NDOC_SRC_BKR1 2'h1
`define NDOC_SRC_BKR2 2'h2
`define NDOC_POL_VOLT 2'h0
`define NDOC_POL_CURR 2'h1
`define NDOC_POL_DUAL 2'h2

`define NDOC_RST_CTRL 8'h00
`define NDOC_RST_K 9'h03F
`define NDOC_MAX_K 9'h1F4
`define NDOC_RST_ZOFF 15'h0000
`define NDOC_MAX_ZOFF 15'h61A8
`define NDOC_RST_ECA 8'hBA
`define NDOC_MAX_ECA 8'h5A
`define NDOC_MIN_ECA 8'hA6
`define NDOC_RST_LIM 7'h5A
`define NDOC_MIN_LIM 7'h28
`define NDOC_MAX_LIM 7'h5A
`define NDOC_RST_PICKUP 15'h0032
`define NDOC_MIN_PICKUP 15'h0002
`define NDOC_MAX_PICKUP 15'h7530
`define NDOC_RST_CUTOFF 16'h0064
`define NDOC_IG_POL_MIN 16'h0032
`define NDOC_I1_RESTRAINT_MIN 16'h0320

`define NDOC_CLK_PERIOD_NS 20
`define NDOC_POWER_CYCLE_US 16667
`define NDOC_REV_PERSIST_MCYC 1250
`define NDOC_FWD_DELAY_MCYC 1500
`define NDOC_REV_PERSIST_CYC ((`NDOC_REV_PERSIST_MCYC * `NDOC_POWER_CYCLE_US + `NDOC_CLK_PERIOD_NS - 1) / `NDOC_CLK_PERIOD_NS)
`define NDOC_FWD_DELAY_CYC ((`NDOC_FWD_DELAY_MCYC * `NDOC_POWER_CYCLE_US + `NDOC_CLK_PERIOD_NS - 1) / `NDOC_CLK_PERIOD_NS)

`endif

// ===== rtl/ndoc_angle_cmp.v
// Phase-angle comparator: tests whether a phasor lies within a symmetric zone
`timescale 1ns/100ps
`default_nettype none
module ndoc_angle_cmp (
    input wire signed [11:0] pol_ang,
    input wire signed [11:0] ref_ang,
    input wire signed [11:0] char_ang,
    input wire [6:0] limit,
    output wire in_zone
);
    localparam signed [11:0] HALF_POS = 12'sh0B3;
    localparam signed [11:0] HALF_NEG = -12'sh0B4;
    localparam signed [11:0] FULL = 12'sh168;

    // Brings an angle back into -180..179 degrees
    function signed [11:0] fold;
        input signed [11:0] a;
        begin
            if (a > HALF_POS) begin
                fold = a - FULL;
            end else if (a < HALF_NEG) begin
                fold = a + FULL;
            end else begin
                fold = a;
            end
        end
    endfunction

    wire signed [11:0] diff0 = pol_ang - ref_ang - char_ang;
    wire signed [11:0] diff = fold(fold(fold(diff0)));
    wire [11:0] mag = diff[11] ? (~diff + 12'h001) : diff;

    assign in_zone = (mag <= {5'h00, limit});
endmodule // ndoc_angle_cmp
`default_nettype wire

// ===== rtl/ndoc_hold_timer.v
// Persistence timer: done once run has stood for LIMIT clock cycles
`timescale 1ns/100ps
`default_nettype none
module ndoc_hold_timer #(
    parameter WIDTH = 21,
    parameter [WIDTH-1:0] LIMIT = 1
) (
    input wire pclk,
    input wire presetn,
    input wire run,
    output wire done
);
    reg [WIDTH-1:0] cnt_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= {WIDTH{1'b0}};
        end else if (!run) begin
            cnt_reg <= {WIDTH{1'b0}};
        end else if (cnt_reg != LIMIT) begin
            cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign done = run && (cnt_reg == LIMIT);
endmodule // ndoc_hold_timer
`default_nettype wire

// ===== rtl/ndoc_direct_oc.v
// Neutral directional overcurrent element with APB settings and event record
//
// Overview of operation
// - Polarizing mode is voltage, current or dual; voltage after reset.
// - Voltage mode polarizes on zero-sequence voltage angle of the chosen source.
// - Polarizing voltage valid only above cut-off; invalid gives no voltage-polarized direction.
// - Current mode uses ground current angle, valid only above 0.05 pu.
// - Dual mode runs both comparisons; either one confirms a direction.
// - Simultaneous forward and reverse: forward wins, reverse suppressed.
// - Polarizing voltage is derived zero-sequence or external auxiliary; derived default.
// - Operating current is restrained derived neutral current or external ground current.
// - Restraint coefficient 0 to 0.500 in 0.001 steps, default 0.063.
// - Offset impedance 0 to 250.00 ohms in 0.01 steps, default zero.
// - Forward characteristic angle -90 to 90 degrees, default -70.
// - Current polarizing uses a fixed zero characteristic angle.
// - Reverse characteristic angle is forward angle turned by 180 degrees.
// - Forward limit angle 40 to 90 degrees, default 90, symmetric.
// - Reverse limit angle 40 to 90 degrees, default 90, symmetric.
// - Forward pickup 0.002 to 30.000 pu, default 0.050 pu.
// - Reverse pickup 0.002 to 30.000 pu independently, default 0.050 pu.
// - Block input inhibits both direction outputs.
// - Event logging, off by default, records output transitions.
// - Function enable, off by default; disabled keeps both outputs low.
// - Source select among line and two breaker sources; line default.
// - Output needs current above its pickup and matching direction.
// - Restraint coefficient forced to zero at or below 0.8 pu positive sequence.
// - Reverse for 1.25 power cycles delays next forward by 1.5 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "ndoc_regs.vh"
module ndoc_direct_oc #(
    parameter [20:0] REV_PERSIST_CYC = `NDOC_REV_PERSIST_CYC,
    parameter [20:0] FWD_DELAY_CYC = `NDOC_FWD_DELAY_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire phasor_strobe,
    input wire block_in,
    input wire [47:0] src_v0_mag,
    input wire [29:0] src_v0_ang,
    input wire [47:0] src_vx_mag,
    input wire [29:0] src_vx_ang,
    input wire [47:0] src_i0_mag,
    input wire [29:0] src_i0_ang,
    input wire [47:0] src_i1_mag,
    input wire [47:0] src_ig_mag,
    input wire [29:0] src_ig_ang,
    output reg forward_fault_flag,
    output reg reverse_fault_flag,
    output reg event_strobe,
    output reg [1:0] event_code
);
    // Settings
    reg [7:0] ctrl_reg;
    reg [8:0] k_reg;
    reg [14:0] zoff_reg;
    reg [7:0] eca_reg;
    reg [6:0] flim_reg;
    reg [6:0] rlim_reg;
    reg [14:0] fpk_reg;
    reg [14:0] rpk_reg;
    reg [15:0] cut_reg;
    // Evaluation and event state
    reg fwd_pick_reg;
    reg rev_pick_reg;
    reg v_ok_reg;
    reg i_ok_reg;
    reg rev_arm_reg;
    reg evt_new_reg;
    reg [1:0] evt_last_reg;
    reg [7:0] evt_cnt_reg;

    wire enable = ctrl_reg[`NDOC_CTRL_EN];
    wire [1:0] src = ctrl_reg[`NDOC_CTRL_SRC_LO +: 2];
    wire [1:0] pol_mode = ctrl_reg[`NDOC_CTRL_POL_LO +: 2];
    wire pv_ext = ctrl_reg[`NDOC_CTRL_PVSEL];
    wire op_ext = ctrl_reg[`NDOC_CTRL_OPSEL];
    wire ev_en = ctrl_reg[`NDOC_CTRL_EVEN];

    // Source selection
    wire [15:0] v0_mag = src_v0_mag[src*16 +: 16];
    wire [9:0] v0_ang = src_v0_ang[src*10 +: 10];
    wire [15:0] vx_mag = src_vx_mag[src*16 +: 16];
    wire [9:0] vx_ang = src_vx_ang[src*10 +: 10];
    wire [15:0] i0_mag = src_i0_mag[src*16 +: 16];
    wire [9:0] i0_ang = src_i0_ang[src*10 +: 10];
    wire [15:0] i1_mag = src_i1_mag[src*16 +: 16];
    wire [15:0] ig_mag = src_ig_mag[src*16 +: 16];
    wire [9:0] ig_ang = src_ig_ang[src*10 +: 10];

    // Polarizing voltage, auxiliary taken at one third
    wire [15:0] pv_mag = pv_ext ? (vx_mag / 16'h0003) : v0_mag;
    wire [9:0] pv_ang10 = pv_ext ? vx_ang : v0_ang;
    wire v_ok = (pv_mag > cut_reg);
    wire i_ok = (ig_mag > `NDOC_IG_POL_MIN);

    // Operating quantity with positive-sequence restraint
    wire [8:0] k_eff = (i1_mag > `NDOC_I1_RESTRAINT_MIN) ? k_reg : 9'h000;
    wire [24:0] k_prod = k_eff * i1_mag;
    wire [24:0] k_div = k_prod / 25'h000_03E8;
    wire [15:0] k_term = k_div[15:0];
    wire [15:0] i_diff = (i0_mag > k_term) ? (i0_mag - k_term) : 16'h0000;
    wire [17:0] iop_calc = {1'b0, i_diff, 1'b0} + {2'b00, i_diff};
    wire [17:0] iop = op_ext ? {2'b00, ig_mag} : iop_calc;

    // Offset term dominance: Z*|I| against |V| scaled by 100
    wire [15:0] z_cur = op_ext ? (ig_mag / 16'h0003) : i0_mag;
    wire [30:0] z_prod = zoff_reg * z_cur;
    wire [22:0] pv_scaled = pv_mag * 7'h64;
    wire z_dom = (z_prod > {8'h00, pv_scaled});

    // Angles widened to 12 bits
    localparam signed [11:0] DEG180 = 12'sh0B4;
    wire signed [11:0] pv_ang = {{2{pv_ang10[9]}}, pv_ang10};
    wire [9:0] ref_ang10 = op_ext ? ig_ang : i0_ang;
    wire signed [11:0] ref_ang = {{2{ref_ang10[9]}}, ref_ang10};
    wire signed [11:0] ig_ang12 = {{2{ig_ang[9]}}, ig_ang};
    wire signed [11:0] i0_ang12 = {{2{i0_ang[9]}}, i0_ang};
    wire signed [11:0] eca_fwd = {{4{eca_reg[7]}}, eca_reg};
    wire signed [11:0] eca_rev = eca_fwd + DEG180;
    // Polarizing phasor -V + Z*I forward and -V - Z*I reverse, taken along its dominant term
    wire signed [11:0] pol_fwd = z_dom ? ref_ang : (pv_ang + DEG180);
    wire signed [11:0] pol_rev = z_dom ? (ref_ang + DEG180) : (pv_ang + DEG180);

    wire v_fwd;
    wire v_rev;
    wire c_fwd;
    wire c_rev;

    ndoc_angle_cmp u_v_fwd (
        .pol_ang(pol_fwd),
        .ref_ang(ref_ang),
        .char_ang(eca_fwd),
        .limit(flim_reg),
        .in_zone(v_fwd)
    );

    ndoc_angle_cmp u_v_rev (
        .pol_ang(pol_rev),
        .ref_ang(ref_ang),
        .char_ang(eca_rev),
        .limit(rlim_reg),
        .in_zone(v_rev)
    );

    ndoc_angle_cmp u_c_fwd (
        .pol_ang(ig_ang12),
        .ref_ang(i0_ang12),
        .char_ang(12'sh000),
        .limit(flim_reg),
        .in_zone(c_fwd)
    );

    ndoc_angle_cmp u_c_rev (
        .pol_ang(ig_ang12),
        .ref_ang(i0_ang12),
        .char_ang(DEG180),
        .limit(rlim_reg),
        .in_zone(c_rev)
    );

    // Direction decision per polarizing mode
    wire use_v = (pol_mode == `NDOC_POL_VOLT) || (pol_mode == `NDOC_POL_DUAL);
    wire use_c = (pol_mode == `NDOC_POL_CURR) || (pol_mode == `NDOC_POL_DUAL);
    wire dir_fwd = (use_v && v_ok && v_fwd) || (use_c && i_ok && c_fwd);
    wire dir_rev_any = (use_v && v_ok && v_rev) || (use_c && i_ok && c_rev);
    wire dir_rev = dir_rev_any && !dir_fwd;

    // Pickup comparisons
    wire fwd_over = (iop > {3'b000, fpk_reg});
    wire rev_over = (iop > {3'b000, rpk_reg});

    // Current reversal timing
    wire rev_persist_done;
    wire fwd_delay_done;

    ndoc_hold_timer #(
        .WIDTH(21),
        .LIMIT(REV_PERSIST_CYC)
    ) u_rev_persist (
        .pclk(pclk),
        .presetn(presetn),
        .run(rev_pick_reg),
        .done(rev_persist_done)
    );

    ndoc_hold_timer #(
        .WIDTH(21),
        .LIMIT(FWD_DELAY_CYC)
    ) u_fwd_delay (
        .pclk(pclk),
        .presetn(presetn),
        .run(fwd_pick_reg && rev_arm_reg),
        .done(fwd_delay_done)
    );

    wire active = enable && !block_in;
    wire fwd_ok = fwd_pick_reg && (!rev_arm_reg || fwd_delay_done);
    wire fwd_next = active && fwd_ok;
    wire rev_next = active && rev_pick_reg && !fwd_ok;
    wire out_change = (fwd_next != forward_fault_flag) || (rev_next != reverse_fault_flag);

    // APB decode
    wire [5:0] widx = paddr[7:2];
    wire setup = psel && !penable;
    wire mapped = (widx <= `NDOC_OFF_EVENT);
    wire wr_en = psel && penable && pready && pwrite && mapped;
    wire evt_set = ev_en && out_change;
    wire evt_clr = wr_en && (widx == `NDOC_OFF_EVENT) && pwdata[0];

    reg [31:0] rd_next;
    always @* begin
        rd_next = 32'h0000_0000;
        case (widx)
            `NDOC_OFF_CTRL: rd_next = {24'h00_0000, ctrl_reg};
            `NDOC_OFF_RESTRAINT: rd_next = {23'h00_0000, k_reg};
            `NDOC_OFF_OFFSET: rd_next = {17'h0_0000, zoff_reg};
            `NDOC_OFF_ANGLES: rd_next = {9'h000, rlim_reg, 1'b0, flim_reg, eca_reg};
            `NDOC_OFF_FWD_PICKUP: rd_next = {17'h0_0000, fpk_reg};
            `NDOC_OFF_REV_PICKUP: rd_next = {17'h0_0000, rpk_reg};
            `NDOC_OFF_CUTOFF: rd_next = {16'h0000, cut_reg};
            `NDOC_OFF_STATUS: rd_next = {25'h000_0000, rev_arm_reg, i_ok_reg, v_ok_reg,
                                         rev_pick_reg, fwd_pick_reg, reverse_fault_flag, forward_fault_flag};
            `NDOC_OFF_EVENT: rd_next = {16'h0000, evt_cnt_reg, 5'h00, evt_last_reg, evt_new_reg};
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Clamp helpers for written settings
    function [14:0] clamp15;
        input [31:0] v;
        input [14:0] lo;
        input [14:0] hi;
        begin
            if (v < {17'h0_0000, lo}) begin
                clamp15 = lo;
            end else if (v > {17'h0_0000, hi}) begin
                clamp15 = hi;
            end else begin
                clamp15 = v[14:0];
            end
        end
    endfunction

    function [6:0] clamp_lim;
        input [6:0] v;
        begin
            if (v < `NDOC_MIN_LIM) begin
                clamp_lim = `NDOC_MIN_LIM;
            end else if (v > `NDOC_MAX_LIM) begin
                clamp_lim = `NDOC_MAX_LIM;
            end else begin
                clamp_lim = v;
            end
        end
    endfunction

    function [7:0] clamp_eca;
        input [7:0] v;
        begin
            if ($signed(v) > $signed(`NDOC_MAX_ECA)) begin
                clamp_eca = `NDOC_MAX_ECA;
            end else if ($signed(v) < $signed(`NDOC_MIN_ECA)) begin
                clamp_eca = `NDOC_MIN_ECA;
            end else begin
                clamp_eca = v;
            end
        end
    endfunction

    // Mode and source codes of 3 fall back to the defaults
    wire [1:0] wr_src = (pwdata[2:1] == 2'h3) ? `NDOC_SRC_LINE : pwdata[2:1];
    wire [1:0] wr_pol = (pwdata[4:3] == 2'h3) ? `NDOC_POL_VOLT : pwdata[4:3];
    wire [8:0] wr_k = (pwdata[31:0] > {23'h00_0000, `NDOC_MAX_K}) ? `NDOC_MAX_K : pwdata[8:0];
    wire [14:0] wr_z = clamp15(pwdata, 15'h0000, `NDOC_MAX_ZOFF);

    // Settings registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `NDOC_RST_CTRL;
            k_reg <= `NDOC_RST_K;
            zoff_reg <= `NDOC_RST_ZOFF;
            eca_reg <= `NDOC_RST_ECA;
            flim_reg <= `NDOC_RST_LIM;
            rlim_reg <= `NDOC_RST_LIM;
            fpk_reg <= `NDOC_RST_PICKUP;
            rpk_reg <= `NDOC_RST_PICKUP;
            cut_reg <= `NDOC_RST_CUTOFF;
        end else if (wr_en) begin
            case (widx)
                `NDOC_OFF_CTRL: ctrl_reg <= {pwdata[7:5], wr_pol, wr_src, pwdata[0]};
                `NDOC_OFF_RESTRAINT: k_reg <= wr_k;
                `NDOC_OFF_OFFSET: zoff_reg <= wr_z;
                `NDOC_OFF_ANGLES: begin
                    eca_reg <= clamp_eca(pwdata[`NDOC_ANG_ECA_LO +: 8]);
                    flim_reg <= clamp_lim(pwdata[`NDOC_ANG_FLIM_LO +: 7]);
                    rlim_reg <= clamp_lim(pwdata[`NDOC_ANG_RLIM_LO +: 7]);
                end
                `NDOC_OFF_FWD_PICKUP: fpk_reg <= clamp15(pwdata, `NDOC_MIN_PICKUP, `NDOC_MAX_PICKUP);
                `NDOC_OFF_REV_PICKUP: rpk_reg <= clamp15(pwdata, `NDOC_MIN_PICKUP, `NDOC_MAX_PICKUP);
                `NDOC_OFF_CUTOFF: cut_reg <= pwdata[15:0];
                default: cut_reg <= cut_reg;
            endcase
        end
    end

    // APB answer: zero wait states, error on unmapped words
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= rd_next;
                pslverr <= !mapped;
            end
        end
    end

    // Evaluation on each phasor update
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_pick_reg <= 1'b0;
            rev_pick_reg <= 1'b0;
            v_ok_reg <= 1'b0;
            i_ok_reg <= 1'b0;
        end else if (phasor_strobe) begin
            fwd_pick_reg <= dir_fwd && fwd_over;
            rev_pick_reg <= dir_rev && rev_over;
            v_ok_reg <= v_ok;
            i_ok_reg <= i_ok;
        end
    end

    // Reversal arming and registered outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rev_arm_reg <= 1'b0;
            forward_fault_flag <= 1'b0;
            reverse_fault_flag <= 1'b0;
        end else begin
            if (rev_persist_done) begin
                rev_arm_reg <= 1'b1;
            end else if (fwd_next || !active) begin
                rev_arm_reg <= 1'b0;
            end
            forward_fault_flag <= fwd_next;
            reverse_fault_flag <= rev_next;
        end
    end

    // Event record, a new event wins over a clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_strobe <= 1'b0;
            event_code <= 2'h0;
            evt_new_reg <= 1'b0;
            evt_last_reg <= 2'h0;
            evt_cnt_reg <= 8'h00;
        end else begin
            event_strobe <= evt_set;
            if (evt_set) begin
                event_code <= {rev_next, fwd_next};
                evt_last_reg <= {rev_next, fwd_next};
                evt_cnt_reg <= evt_cnt_reg + 8'h01;
                evt_new_reg <= 1'b1;
            end else if (evt_clr) begin
                evt_new_reg <= 1'b0;
            end
        end
    end
endmodule // ndoc_direct_oc
`default_nettype wire

// ===== verification/ndoc_direct_oc_properties.sv
// Concurrent checks on the ports of the directional overcurrent element
`timescale 1ns/100ps
`default_nettype none
module ndoc_direct_oc_props #(
    parameter [20:0] REV_PERSIST_CYC = 21'h00_0008,
    parameter [20:0] FWD_DELAY_CYC = 21'h00_000C
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic block_in,
    input wire logic forward_fault_flag,
    input wire logic reverse_fault_flag,
    input wire logic event_strobe,
    input wire logic [1:0] event_code
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence apb_done_s;
        psel && penable && pready;
    endsequence

    ready_follows_a: assert property (apb_setup_s |=> apb_done_s)
        else $error("access phase not answered in one cycle");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_idle_a: assert property (!psel |=> !pready)
        else $error("pready without a request");
    slverr_map_a: assert property (apb_done_s |-> pslverr == (paddr[7:2] > 6'h08))
        else $error("pslverr does not match address map");
    unmapped_zero_a: assert property (apb_done_s and pslverr and !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    prdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("prdata changed without a setup");
    fwd_priority_a: assert property (!(forward_fault_flag && reverse_fault_flag))
        else $error("both direction flags high");
    block_quiet_a: assert property (block_in |=> !forward_fault_flag && !reverse_fault_flag)
        else $error("flag high while blocked");
    event_code_a: assert property (event_strobe |-> event_code == {reverse_fault_flag, forward_fault_flag})
        else $error("event code differs from flags");
    event_cause_a: assert property (event_strobe |-> $changed(forward_fault_flag) || $changed(reverse_fault_flag))
        else $error("event without flag change");
endmodule // ndoc_direct_oc_props
`default_nettype wire

// ===== verification/ndoc_front_model.sv
// Behavioural phasor front end placing one fault case into a chosen source slot
`timescale 1ns/100ps
`default_nettype none
module ndoc_front_model #(
    parameter PERIOD = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] kind,
    input wire logic [1:0] src,
    output logic phasor_strobe,
    output logic [47:0] v0_mag,
    output logic [29:0] v0_ang,
    output logic [47:0] i0_mag,
    output logic [47:0] ig_mag,
    output logic [29:0] ig_ang
);
    // Kind: 0 quiet, 1 forward, 2 reverse, 3 forward with weak voltage
    int cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            phasor_strobe <= 1'b0;
            v0_mag <= '0;
            v0_ang <= '0;
            i0_mag <= '0;
            ig_mag <= '0;
            ig_ang <= '0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            phasor_strobe <= (cnt == 0);
            v0_mag <= '0;
            v0_ang <= '0;
            i0_mag <= '0;
            ig_mag <= '0;
            ig_ang <= '0;
            v0_mag[src*16 +: 16] <= (kind == 2'h3) ? 16'h0032 : 16'h03E8;
            v0_ang[src*10 +: 10] <= (kind == 2'h2) ? 10'h3BA : 10'h06E;
            i0_mag[src*16 +: 16] <= (kind == 2'h0) ? 16'h0000 : 16'h0064;
            ig_mag[src*16 +: 16] <= 16'h0064;
            ig_ang[src*10 +: 10] <= (kind == 2'h2) ? 10'h34C : 10'h000;
        end
    end
endmodule // ndoc_front_model
`default_nettype wire

// ===== verification/ndoc_direct_oc_tb_top.sv
// Self-checking bench for the directional overcurrent element
`timescale 1ns/100ps
`default_nettype none
module ndoc_direct_oc_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic block_in = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [1:0] kind = 2'h0;
    logic [1:0] src = 2'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, strobe, fwd, rev, ev_stb, re;
    logic [1:0] ev_code;
    logic [47:0] v0m, i0m, igm;
    logic [47:0] vxm = 48'h0000_0000_0000;
    logic [47:0] i1m = 48'h0000_0000_0000;
    logic [29:0] v0a, iga;
    logic [31:0] dflt [0:6];
    int err_count = 0;
    int num_checks = 0;
    always #10 pclk = ~pclk;

    ndoc_front_model #(.PERIOD(6)) u_front (.pclk(pclk), .presetn(presetn), .kind(kind), .src(src),
        .phasor_strobe(strobe), .v0_mag(v0m), .v0_ang(v0a), .i0_mag(i0m), .ig_mag(igm), .ig_ang(iga));
    ndoc_direct_oc #(.REV_PERSIST_CYC(21'h00_0008), .FWD_DELAY_CYC(21'h00_000C)) u_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .phasor_strobe(strobe), .block_in(block_in),
        .src_v0_mag(v0m), .src_v0_ang(v0a), .src_vx_mag(vxm), .src_vx_ang(30'h0000_0000),
        .src_i0_mag(i0m), .src_i0_ang(30'h0000_0000), .src_i1_mag(i1m), .src_ig_mag(igm),
        .src_ig_ang(iga), .forward_fault_flag(fwd), .reverse_fault_flag(rev), .event_strobe(ev_stb),
        .event_code(ev_code));

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("wait states", 32'h0000_0000, 32'(n - 1));
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), exp, rv);
    endtask

    // Three strobes plus latency, then sample the flags away from the edge
    task automatic fl(input logic [1:0] exp);
        repeat (20) @(posedge pclk);
        @(negedge pclk);
        chk("flags", {30'h0000_0000, exp}, {30'h0000_0000, rev, fwd});
    endtask

    initial begin
        dflt = '{32'h0000_0000, 32'h0000_003F, 32'h0000_0000, 32'h005A_5ABA, 32'h0000_0032,
            32'h0000_0032, 32'h0000_0064};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(8'(i * 4), dflt[i]);
        apb(1'b0, 8'h24, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0000_0000, re});
        chk("unmapped", 32'h0000_0000, rv);
        wr(8'h04, 32'h0000_03FF);
        rd(8'h04, 32'h0000_01F4);
        wr(8'h04, 32'h0000_003F);
        wr(8'h0C, 32'h0010_10BA);
        rd(8'h0C, 32'h0028_28BA);
        wr(8'h0C, 32'h005A_5ABA);
        wr(8'h10, 32'h0000_0000);
        rd(8'h10, 32'h0000_0002);
        wr(8'h10, 32'h0000_0032);
        kind <= 2'h1;
        fl(2'h0);
        wr(8'h00, 32'h0000_0081);
        fl(2'h1);
        rd(8'h20, 32'h0000_0103);
        rd(8'h1C, 32'h0000_0035);
        wr(8'h20, 32'h0000_0001);
        rd(8'h20, 32'h0000_0102);
        block_in <= 1'b1;
        fl(2'h0);
        block_in <= 1'b0;
        fl(2'h1);
        wr(8'h10, 32'h0000_012C);
        fl(2'h0);
        wr(8'h10, 32'h0000_012B);
        fl(2'h1);
        wr(8'h10, 32'h0000_0096);
        i1m <= 48'h0000_0000_0321;
        fl(2'h0);
        i1m <= 48'h0000_0000_0320;
        fl(2'h1);
        wr(8'h10, 32'h0000_0032);
        src <= 2'h1;
        fl(2'h0);
        wr(8'h00, 32'h0000_0083);
        fl(2'h1);
        wr(8'h00, 32'h0000_0085);
        fl(2'h0);
        src <= 2'h0;
        wr(8'h00, 32'h0000_00A1);
        fl(2'h0);
        vxm <= 48'h0000_0000_0BB8;
        fl(2'h2);
        wr(8'h00, 32'h0000_0081);
        fl(2'h1);
        kind <= 2'h3;
        fl(2'h0);
        wr(8'h00, 32'h0000_0089);
        fl(2'h1);
        kind <= 2'h2;
        fl(2'h2);
        wr(8'h00, 32'h0000_0091);
        kind <= 2'h3;
        fl(2'h1);
        wr(8'h00, 32'h0000_009F);
        rd(8'h00, 32'h0000_0081);
        kind <= 2'h2;
        wr(8'h14, 32'h0000_012C);
        fl(2'h0);
        wr(8'h14, 32'h0000_0032);
        fl(2'h2);
        kind <= 2'h1;
        repeat (2) @(posedge pclk iff strobe === 1'b1);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk("held forward", 32'h0000_0000, {31'h0000_0000, fwd});
        fl(2'h1);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        wrap_up();
    end
endmodule // ndoc_direct_oc_tb_top

bind ndoc_direct_oc ndoc_direct_oc_props #(.REV_PERSIST_CYC(REV_PERSIST_CYC), .FWD_DELAY_CYC(FWD_DELAY_CYC)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .block_in(block_in),
    .forward_fault_flag(forward_fault_flag), .reverse_fault_flag(reverse_fault_flag),
    .event_strobe(event_strobe), .event_code(event_code));
`default_nettype wire
